// File: logic/mesc_pkg.sv
// ***************************************************************
// shared constants for the error statistics counters
// ***************************************************************
package mesc_pkg;

  // ***************************************************************
  // register map (byte addresses on the register bus)
  // ***************************************************************
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] OFF_UNDERRUN  = 8'h64;  // transmit_underrun_count
  localparam logic [7:0] OFF_CARRIER   = 8'h68;  // carrier_sense_error_count
  localparam logic [7:0] OFF_NO_BUFFER = 8'h6c;  // no_buffer_drop_count
  localparam logic [7:0] OFF_OVERRUN   = 8'h70;  // receive_dma_overrun_count
  localparam logic [7:0] OFF_SYMBOL    = 8'h74;  // symbol_error_frame_count
  localparam logic [7:0] OFF_OVERSIZE  = 8'h78;  // oversize_clean_frame_count
  localparam logic [7:0] OFF_JABBER    = 8'h7c;  // jabber_frame_count
  localparam logic [7:0] OFF_UNDERSIZE = 8'h80;  // undersize_frame_count
  localparam logic [7:0] OFF_HEARTBEAT = 8'h84;  // heartbeat_test_fail_count
  localparam logic [7:0] OFF_MISMATCH  = 8'h88;  // length_mismatch_count
  localparam logic [7:0] OFF_MODE      = 8'hfc;  // operating mode bits

  // ***************************************************************
  // counter storage layout
  // ***************************************************************
  localparam int NUM_CNT = 10;  // counters held in the store
  localparam int IDX_W   = 4;   // counter index width
  localparam int CNT_W   = 16;  // widest counter field
  localparam int NARROW_W = 8;  // width of every other counter field
  localparam int DATA_W  = 32;  // bus data width
  localparam logic [IDX_W-1:0] IDX_UNDERRUN  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_CARRIER   = 4'h1;
  localparam logic [IDX_W-1:0] IDX_NO_BUFFER = 4'h2;
  localparam logic [IDX_W-1:0] IDX_OVERRUN   = 4'h3;
  localparam logic [IDX_W-1:0] IDX_SYMBOL    = 4'h4;
  localparam logic [IDX_W-1:0] IDX_OVERSIZE  = 4'h5;
  localparam logic [IDX_W-1:0] IDX_JABBER    = 4'h6;
  localparam logic [IDX_W-1:0] IDX_UNDERSIZE = 4'h7;
  localparam logic [IDX_W-1:0] IDX_HEARTBEAT = 4'h8;
  localparam logic [IDX_W-1:0] IDX_MISMATCH  = 4'h9;
  localparam logic [CNT_W-1:0] CNT_RESET     = 16'h0000;

  // ***************************************************************
  // mode register fields
  // ***************************************************************
  localparam int             MODE_W        = 4;
  localparam int             MODE_FULL_DUP = 0;  // full-duplex operation
  localparam int             MODE_BIG      = 1;  // big_frame_enable
  localparam int             MODE_JUMBO    = 2;  // jumbo_frame_enable
  localparam int             MODE_LEN_CHK  = 3;  // length_check_enable
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

  // ***************************************************************
  // frame length thresholds, in bytes
  // ***************************************************************
  localparam int              LEN_W        = 14;
  localparam logic [LEN_W-1:0] LEN_MIN     = 14'h0040;  // 64
  localparam logic [LEN_W-1:0] LEN_MAX_STD = 14'h05ee;  // 1518
  localparam logic [LEN_W-1:0] LEN_MAX_BIG = 14'h0600;  // 1536
  localparam logic [LEN_W-1:0] LEN_MAX_JUM = 14'h2800;  // 10240
  localparam logic [LEN_W-1:0] LEN_OVERHEAD = 14'h0012; // header and fcs
  localparam logic [15:0]      TYPE_ID_MIN = 16'h0600;

  // ***************************************************************
  // heartbeat window timing
  // ***************************************************************
  localparam int CLOCK_NS  = 100;  // 10 MHz peripheral clock
  localparam int BIT_NS    = 100;  // one bit time on a 10 Mb/s link
  localparam int SQE_BITS  = 96;   // interframe gap in bit times
  localparam int SQE_NS    = SQE_BITS * BIT_NS;
  localparam int SQE_CYC_I = (SQE_NS / CLOCK_NS < 1) ? 1 : SQE_NS / CLOCK_NS;
  localparam int SQE_CNT_W = 7;
  localparam logic [SQE_CNT_W-1:0] SQE_CYCLES = SQE_CNT_W'(SQE_CYC_I);

  // ***************************************************************
  // bus sequencer states
  // ***************************************************************
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_FETCH  = 2'b01,
    BUS_ANSWER = 2'b10
  } mesc_bus_state_t;

  // keep only the field bits of a counter, upper bits read as zero
  function automatic logic [CNT_W-1:0] mesc_mask(logic [IDX_W-1:0] idx);
    mesc_mask = (idx == IDX_NO_BUFFER) ? {CNT_W{1'b1}}
                                       : CNT_W'({NARROW_W{1'b1}});
  endfunction : mesc_mask

endpackage : mesc_pkg

// File: logic/mesc_cnt_if.sv
`timescale 1ns/1ps
// ***************************************************************
// link between the bus/event logic and the counter store
// ***************************************************************
interface mesc_cnt_if;
  import mesc_pkg::*;
  logic [NUM_CNT-1:0] inc;      // one-cycle increment request per counter
  logic               wr_en;    // software write of one counter
  logic [IDX_W-1:0]   wr_idx;   // counter written
  logic [CNT_W-1:0]   wr_data;  // value written
  logic [IDX_W-1:0]   rd_idx;   // counter read
  logic [CNT_W-1:0]   rd_data;  // registered read value

  modport ctrl  (output inc, wr_en, wr_idx, wr_data, rd_idx,
                 input  rd_data);
  modport store (input  inc, wr_en, wr_idx, wr_data, rd_idx,
                 output rd_data);
endinterface : mesc_cnt_if

// File: logic/mesc_counter_mem.sv
`timescale 1ns/1ps
// ***************************************************************
// counter store: all counters, one write port, registered read
// ***************************************************************
module mesc_counter_mem
  import mesc_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // access from the control logic
  mesc_cnt_if.store cnt
);

  typedef struct packed {
    logic [NUM_CNT-1:0][CNT_W-1:0] value;    // counter contents
    logic [CNT_W-1:0]              rd_data;  // read register
  } mesc_mem_state_t;

  mesc_mem_state_t state;       // registered state
  mesc_mem_state_t next_state;  // next state

  // write first, then add the increment, so no event is lost
  always_comb begin
    logic [CNT_W-1:0] v;
    v = CNT_RESET;
    next_state = state;
    for (int i = 0; i < NUM_CNT; i++) begin
      v = state.value[i];
      if (cnt.wr_en && cnt.wr_idx == IDX_W'(i)) begin
        v = cnt.wr_data;
      end
      if (cnt.inc[i]) begin
        v = v + 1'b1;
      end
      next_state.value[i] = v & mesc_mask(IDX_W'(i));
    end
    // out-of-range index reads zero rather than an undefined word
    next_state.rd_data = (int'(cnt.rd_idx) < NUM_CNT)
                         ? state.value[cnt.rd_idx] : CNT_RESET;
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cnt.rd_data = state.rd_data;

endmodule : mesc_counter_mem

// File: logic/mesc_sqe_watch.sv
`timescale 1ns/1ps
// ***************************************************************
// heartbeat watch: collision expected after transmit ends
// ***************************************************************
module mesc_sqe_watch
  import mesc_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // link pins and mode
  input  wire logic half_duplex,
  input  wire logic tx_en,
  input  wire logic col,
  // result
  output logic      sqe_fail
);

  typedef struct packed {
    logic                 tx_en_d;  // transmit enable, one cycle late
    logic                 armed;    // window open
    logic [SQE_CNT_W-1:0] left;     // cycles left in the window
    logic                 fail;     // one-cycle failure pulse
  } mesc_sqe_state_t;

  mesc_sqe_state_t state;       // registered state
  mesc_sqe_state_t next_state;  // next state

  // open the window on the falling transmit enable, close on collision
  always_comb begin
    next_state         = state;
    next_state.fail    = 1'b0;
    next_state.tx_en_d = tx_en;
    if (state.armed) begin
      if (tx_en || col) begin
        next_state.armed = 1'b0;  // new frame or heartbeat seen
      end else if (state.left == SQE_CNT_W'(1)) begin
        next_state.armed = 1'b0;  // window ran out silent
        next_state.fail  = 1'b1;
      end else begin
        next_state.left = state.left - 1'b1;
      end
    end
    // full duplex never arms the window
    if (!tx_en && state.tx_en_d && half_duplex) begin
      next_state.armed = 1'b1;
      next_state.left  = SQE_CYCLES;
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sqe_fail = state.fail;

endmodule : mesc_sqe_watch

// File: logic/mesc_stats_top.sv
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module mesc_stats_top
  import mesc_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // register bus slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  // transmit path pins
  input  wire logic              tx_en,
  input  wire logic              crs,
  input  wire logic              col,
  // transmit frame outcome
  input  wire logic              tx_done,
  input  wire logic              tx_underrun,
  input  wire logic              tx_collision,
  // receive path pins
  input  wire logic              rx_dv,
  input  wire logic              rx_er,
  // receive frame outcome
  input  wire logic              rx_done,
  input  wire logic [LEN_W-1:0]  rx_length,
  input  wire logic [15:0]       rx_length_field,
  input  wire logic              rx_crc_error,
  input  wire logic              rx_align_error,
  input  wire logic              rx_addr_match,
  input  wire logic              rx_no_buffer,
  input  wire logic              rx_dma_overrun
);

  // ***************************************************************
  // helper functions
  // ***************************************************************

  // true for an aligned address inside the counter block
  function automatic logic is_counter(logic [ADDR_W-1:0] a);
    is_counter = (a >= OFF_UNDERRUN) && (a <= OFF_MISMATCH) &&
                 (a[1:0] == 2'b00);
  endfunction : is_counter

  // counter index of an address inside the block
  function automatic logic [IDX_W-1:0] index_of(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFF_UNDERRUN;
    index_of = d[IDX_W+1:2];
  endfunction : index_of

  // largest valid frame for the current mode
  function automatic logic [LEN_W-1:0] max_len(logic [MODE_W-1:0] m);
    if (m[MODE_JUMBO]) begin
      max_len = LEN_MAX_JUM;
    end else if (m[MODE_BIG]) begin
      max_len = LEN_MAX_BIG;
    end else begin
      max_len = LEN_MAX_STD;
    end
  endfunction : max_len

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    mesc_bus_state_t   bus_state;      // read sequencer
    logic [DATA_W-1:0] readdata;       // read answer register
    logic [MODE_W-1:0] mode;           // operating mode bits
    logic              rx_sym;         // rx_er seen in this frame
    logic              crs_seen;       // carrier came during transmit
    logic              crs_lost;       // carrier went after it came
    logic              last_underrun;  // last frame was abandoned
  } mesc_top_state_t;

  mesc_top_state_t state;       // registered state
  mesc_top_state_t next_state;  // next state

  logic [NUM_CNT-1:0] inc;       // increments for this cycle
  logic               sqe_fail;  // heartbeat missing after a frame
  logic               half_dup;  // half-duplex operation
  logic [CNT_W-1:0]   rd_word;   // value from the counter store

  mesc_cnt_if cnt_bus ();

  // ***************************************************************
  // counter store and heartbeat watch
  // ***************************************************************
  mesc_counter_mem u_mem (
    .clock (clock),
    .rst   (rst),
    .cnt   (cnt_bus.store)
  );

  mesc_sqe_watch u_sqe (
    .clock       (clock),
    .rst         (rst),
    .half_duplex (half_dup),
    .tx_en       (tx_en),
    .col         (col),
    .sqe_fail    (sqe_fail)
  );

  assign half_dup = !state.mode[MODE_FULL_DUP];
  assign rd_word  = cnt_bus.rd_data;

  // ***************************************************************
  // frame classification
  // ***************************************************************

  // every counter event but the heartbeat one is decided from the frame outcome strobes;
  // several counters may step in the same cycle, the store has one
  // adder per counter so nothing has to be queued
  always_comb begin
    logic              sym;        // symbol error in this frame
    logic              bad;        // crc, alignment or symbol error
    logic              too_long;   // beyond the valid maximum
    logic              too_short;  // below the valid minimum
    logic [LEN_W-1:0]  payload;    // measured data length
    sym       = state.rx_sym || (rx_dv && rx_er);
    bad       = rx_crc_error || rx_align_error || sym;
    too_long  = rx_length > max_len(state.mode);
    too_short = rx_length < LEN_MIN;
    payload   = (rx_length > LEN_OVERHEAD) ? rx_length - LEN_OVERHEAD
                                           : '0;
    inc = '0;

    // transmit side
    if (tx_done) begin
      if (tx_underrun) begin
        // an abandoned frame steps this counter and nothing else
        inc[IDX_UNDERRUN] = 1'b1;
      end else if (half_dup && !tx_collision &&
                   (!state.crs_seen || state.crs_lost)) begin
        // only effect of a carrier error is this one step
        inc[IDX_CARRIER] = 1'b1;
      end
    end

    // a missing heartbeat after an abandoned frame is not counted
    if (sqe_fail && !state.last_underrun) begin
      inc[IDX_HEARTBEAT] = 1'b1;
    end

    // receive side
    if (rx_done) begin
      if (rx_addr_match && rx_no_buffer) begin
        inc[IDX_NO_BUFFER] = 1'b1;
      end
      if (rx_addr_match && rx_dma_overrun) begin
        inc[IDX_OVERRUN] = 1'b1;
      end
      if (sym) begin
        inc[IDX_SYMBOL] = 1'b1;
      end
      // symbol error on a long frame lands in jabber, not fcs
      // a valid-length one is left to the fcs/alignment counters
      if (too_long && !bad) begin
        inc[IDX_OVERSIZE] = 1'b1;
      end
      if (too_long && bad) begin
        inc[IDX_JABBER] = 1'b1;
      end
      if (too_short && !bad) begin
        inc[IDX_UNDERSIZE] = 1'b1;
      end
      // type frames and oversize frames are never checked
      if (state.mode[MODE_LEN_CHK] && rx_length_field < TYPE_ID_MIN &&
          !too_long && payload < LEN_W'(rx_length_field)) begin
        inc[IDX_MISMATCH] = 1'b1;
      end
    end
  end

  // ***************************************************************
  // bus slave and frame state
  // ***************************************************************

  // waitrequest drops at once for a write and in the answer cycle of
  // a read; the store's registered read and the answer register cost one extra cycle each
  always_comb begin
    waitrequest = !((write && state.bus_state == BUS_IDLE) ||
                    (read && state.bus_state == BUS_ANSWER));
  end

  // next state: bus sequencing, mode writes, per-frame flags
  always_comb begin
    next_state      = state;
    cnt_bus.wr_en   = 1'b0;
    cnt_bus.wr_idx  = index_of(address);
    cnt_bus.wr_data = writedata[CNT_W-1:0];
    cnt_bus.rd_idx  = index_of(address);

    // software write: counter, mode, or ignored when unmapped
    if (write && state.bus_state == BUS_IDLE) begin
      if (address == OFF_MODE) begin
        next_state.mode = writedata[MODE_W-1:0];
      end else if (is_counter(address)) begin
        cnt_bus.wr_en = 1'b1;
      end
    end

    // read sequencer
    case (state.bus_state)
      BUS_IDLE: begin
        if (read) begin
          next_state.bus_state = BUS_FETCH;  // store reads this edge
        end
      end
      BUS_FETCH: begin
        // upper bits above each field read as zero
        if (address == OFF_MODE) begin
          next_state.readdata = DATA_W'(state.mode);
        end else if (is_counter(address)) begin
          next_state.readdata = DATA_W'(rd_word);
        end else begin
          next_state.readdata = '0;  // unmapped reads zero
        end
        next_state.bus_state = BUS_ANSWER;
      end
      BUS_ANSWER: begin
        next_state.bus_state = BUS_IDLE;  // answer taken this edge
      end
      default: begin
        next_state.bus_state = BUS_IDLE;
      end
    endcase

    // rx_er is remembered over the whole reception
    if (rx_done) begin
      next_state.rx_sym = 1'b0;
    end else if (rx_dv && rx_er) begin
      next_state.rx_sym = 1'b1;
    end

    // carrier is tracked only while the frame goes out
    if (tx_done) begin
      next_state.crs_seen      = 1'b0;
      next_state.crs_lost      = 1'b0;
      next_state.last_underrun = tx_underrun;
    end else if (tx_en) begin
      if (crs) begin
        next_state.crs_seen = 1'b1;
      end else if (state.crs_seen) begin
        next_state.crs_lost = 1'b1;
      end
    end
  end

  assign cnt_bus.inc = inc;

  // state register; every counter and flag starts at zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state           <= '0;
      state.bus_state <= BUS_IDLE;
      state.mode      <= MODE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign readdata = state.readdata;

endmodule : mesc_stats_top

// File: verif/mesc_stats_top_asserts.sv
`timescale 1ns/1ps
// ***************************************************************
// bus-side checks of the counter block
// ***************************************************************
module mesc_stats_top_asserts
  import mesc_pkg::*;
(
  // clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // register bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic              waitrequest,
  // frame outcomes
  input wire logic              tx_done,
  input wire logic              tx_underrun,
  input wire logic              rx_done
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  wire logic ans = read && !waitrequest;  // read answered this cycle
  chk_write_no_wait: assert property (write |-> !waitrequest)
    else $error("write was stalled");
  chk_read_two_waits: assert property (
    $rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("read answer not in its third cycle");
  chk_no_early_answer: assert property (
    ans |-> $past(read) && $past(read, 2))
    else $error("read answered too early");
  chk_data_stands: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  chk_reset_clear: assert property ($fell(rst) |-> readdata == '0)
    else $error("read data not clear after reset");
  chk_wide_field: assert property (
    ans && address == OFF_NO_BUFFER |-> readdata[31:16] == '0)
    else $error("wide counter upper bits set");
  chk_narrow_field: assert property (
    ans && address != OFF_NO_BUFFER |-> readdata[31:8] == '0)
    else $error("narrow counter upper bits set");
  chk_unmapped_zero: assert property (ans && address != OFF_MODE &&
    (address < OFF_UNDERRUN || address > OFF_MISMATCH) |-> readdata == '0)
    else $error("unmapped read not zero");
  // main traffic kinds seen at least once
  cover property (ans && address == OFF_JABBER);
  cover property (tx_done && tx_underrun);
  cover property (rx_done);
endmodule : mesc_stats_top_asserts

bind mesc_stats_top mesc_stats_top_asserts chk_u (
  .clock, .rst, .address, .read, .write, .readdata, .waitrequest,
  .tx_done, .tx_underrun, .rx_done);

// File: verif/mesc_phy_model.sv
`timescale 1ns/1ps
// ***************************************************************
// link partner: carrier echo and heartbeat pulse
// ***************************************************************
module mesc_phy_model (
  // clock
  input  wire logic       clock,
  // bench controls
  input  wire logic [1:0] crs_mode,  // 0 none, 1 echo, 2 echo then drop
  input  wire logic       sqe_on,    // heartbeat after each frame
  // link pins
  input  wire logic       tx_en,
  output logic            crs,
  output logic            col
);
  logic [7:0] on_cnt  = 8'h00;  // cycles of transmit so far
  logic [7:0] off_cnt = 8'hff;  // cycles since transmit ended, saturating
  // time both phases of the transmit enable
  always_ff @(posedge clock) begin
    on_cnt  <= tx_en ? on_cnt + 8'h01 : 8'h00;
    off_cnt <= tx_en ? 8'h00 : off_cnt + {7'h00, off_cnt != 8'hff};
  end
  // carrier echoes our transmission; mode 2 loses it after three cycles
  assign crs = tx_en && (crs_mode == 2'h1 ||
                         (crs_mode == 2'h2 && on_cnt < 8'h03));
  // heartbeat well inside the gap, so a slow window still catches it
  assign col = sqe_on && off_cnt >= 8'h0a && off_cnt < 8'h14;
endmodule : mesc_phy_model

// File: verif/mesc_stats_top_tb.sv
`timescale 1ns/1ps
// ***************************************************************
// self-checking bench for the statistics counters
// ***************************************************************
module mesc_stats_top_tb;
  import mesc_pkg::*;
  logic              clock = 1'b0;     // 10 MHz
  logic              rst   = 1'b1;     // held for ten cycles
  logic [ADDR_W-1:0] address;          // bus request
  logic [DATA_W-1:0] writedata, readdata, v;
  logic              read, write, waitrequest;
  logic              tx_en, crs, col, tx_done, tx_underrun, tx_collision;
  logic              rx_dv, rx_er, rx_done, rx_crc_error, rx_align_error;
  logic              rx_addr_match, rx_no_buffer, rx_dma_overrun, sqe_on;
  logic [LEN_W-1:0]  rx_length;
  logic [15:0]       rx_length_field;
  logic [1:0]        crs_mode;
  logic [31:0]       exp_cnt [NUM_CNT];  // expected counter values
  logic [31:0]       exp_q [$];          // notes for pending reads
  int                error_cnt = 0, checks = 0, cycles = 0;

  mesc_stats_top dut_u (.clock, .rst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .tx_en, .crs, .col, .tx_done, .tx_underrun,
    .tx_collision, .rx_dv, .rx_er, .rx_done, .rx_length, .rx_length_field,
    .rx_crc_error, .rx_align_error, .rx_addr_match, .rx_no_buffer,
    .rx_dma_overrun);
  mesc_phy_model phy_u (.clock, .crs_mode, .sqe_on, .tx_en, .crs, .col);

  initial begin
    forever #50 clock = ~clock;
  end
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // read answers are matched against the oldest note
  always @(posedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      compare(readdata, exp_q.pop_front());
    end
  end

  task automatic compare(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : compare
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // bus cycles hold until waitrequest is seen low, then idle one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    address <= a;
    read    <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    read <= 1'b0;
    @(posedge clock);
  endtask : rd
  // field width: the no-buffer counter is the only 16-bit one
  function automatic logic [31:0] fm(input int i);
    return (i == 2) ? 32'h0000ffff : 32'h000000ff;
  endfunction : fm
  // add the expected increments, wrapping, then read every counter
  task automatic bump(input logic [9:0] inc);
    for (int i = 0; i < NUM_CNT; i++) begin
      exp_cnt[i] = (exp_cnt[i] + inc[i]) & fm(i);
      rd(OFF_UNDERRUN + 8'(4 * i), exp_cnt[i]);
    end
  endtask : bump
  task automatic tx_case(input logic fd, input logic s, input logic u,
                         input logic c, input logic [1:0] m,
                         input logic [9:0] inc);
    wr(OFF_MODE, {31'h0, fd});
    crs_mode <= m;
    sqe_on   <= s;
    tx_en    <= 1'b1;
    repeat (8) @(posedge clock);
    tx_en        <= 1'b0;
    tx_done      <= 1'b1;
    tx_underrun  <= u;
    tx_collision <= c;
    @(posedge clock);
    tx_done <= 1'b0;
    repeat (110) @(posedge clock);  // past the 96-cycle window
    bump(inc);
  endtask : tx_case
  // flags f: symbol error, crc, align, match, no buffer, dma overrun
  task automatic rx_case(input logic [3:0] md, input logic [LEN_W-1:0] len,
                         input logic [15:0] lf, input logic [5:0] f,
                         input logic [9:0] inc);
    int k;
    k = $urandom_range(4, 1);
    wr(OFF_MODE, {28'h0, md});
    for (int j = 0; j < 6; j++) begin
      rx_dv <= 1'b1;
      rx_er <= f[5] && j == k;
      @(posedge clock);
    end
    rx_dv           <= 1'b0;
    rx_er           <= 1'b0;
    rx_done         <= 1'b1;
    rx_length       <= len;
    rx_length_field <= lf;
    {rx_crc_error, rx_align_error, rx_addr_match, rx_no_buffer,
     rx_dma_overrun} <= f[4:0];
    @(posedge clock);
    rx_done <= 1'b0;
    @(posedge clock);
    bump(inc);
  endtask : rx_case

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {address, writedata, read, write, tx_en, tx_done, tx_underrun,
     tx_collision, rx_dv, rx_er, rx_done, rx_length, rx_length_field,
     rx_crc_error, rx_align_error, rx_addr_match, rx_no_buffer,
     rx_dma_overrun, crs_mode, sqe_on} = '0;
    foreach (exp_cnt[i]) exp_cnt[i] = '0;
    void'($urandom(80));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bump(10'h0);
    rd(8'h60, 32'h0);
    rd(8'h90, 32'h0);
    for (int i = 0; i < NUM_CNT; i++) begin
      v = $urandom;
      wr(OFF_UNDERRUN + 8'(4 * i), v);
      exp_cnt[i] = v & fm(i);
    end
    wr(OFF_UNDERRUN, 32'hffffffff);
    exp_cnt[0] = 32'hff;  // next underrun wraps it
    tx_case(1'b0, 1'b1, 1'b0, 1'b0, 2'h1, 10'h0);
    tx_case(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 10'h002);
    tx_case(1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 10'h002);
    tx_case(1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 10'h100);
    tx_case(1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 10'h001);
    tx_case(1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 10'h0);
    tx_case(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 10'h0);
    rx_case(4'h0, 14'h064, 16'h0, 6'h20, 10'h010);
    rx_case(4'h0, 14'h640, 16'h0, 6'h20, 10'h050);
    rx_case(4'h0, 14'h640, 16'h0, 6'h10, 10'h040);
    rx_case(4'h0, 14'h5ee, 16'h0, 6'h00, 10'h0);
    rx_case(4'h0, 14'h5ef, 16'h0, 6'h00, 10'h020);
    rx_case(4'h2, 14'h601, 16'h0, 6'h00, 10'h020);
    rx_case(4'h6, 14'h2800, 16'h0, 6'h00, 10'h0);
    rx_case(4'h4, 14'h2801, 16'h0, 6'h00, 10'h020);
    rx_case(4'h0, 14'h03f, 16'h0, 6'h00, 10'h080);
    rx_case(4'h0, 14'h03f, 16'h0, 6'h10, 10'h0);
    rx_case(4'h0, 14'h064, 16'h0, 6'h06, 10'h004);
    rx_case(4'h0, 14'h064, 16'h0, 6'h05, 10'h008);
    rx_case(4'h0, 14'h064, 16'h0100, 6'h00, 10'h0);
    rx_case(4'h8, 14'h064, 16'h0100, 6'h00, 10'h200);
    rx_case(4'h8, 14'h064, 16'h0800, 6'h00, 10'h0);
    rx_case(4'h8, 14'h5ef, 16'h05ff, 6'h00, 10'h020);
    rd(OFF_MODE, 32'h8);
    complete_run();
  end
endmodule : mesc_stats_top_tb
